// ### pkg/pgb_pkg.sv
// Purpose: Shared constants for the three-controller I/O bank.
// Assumes: One 32-bit word per register, byte addresses, aligned word accesses only.
// Notes:   Register offsets inside each 4 KB window are fixed here and used by the bank and its checks.
package pgb_pkg;
    localparam int NUM_CTRL  = 3;
    localparam int WORD_W    = 32;
    localparam int PINS_C0   = 29;
    localparam int PINS_C1   = 29;
    localparam int PINS_C2   = 13;
    localparam int PINS_INP  = 14;
    localparam int PINS_IO   = PINS_C0 + PINS_C1 + PINS_C2;
    localparam int PINS_ALL  = PINS_IO + PINS_INP;
    localparam int C1_LOW    = PINS_C0;
    localparam int C2_LOW    = PINS_C0 + PINS_C1;
    localparam int INP_LOW   = PINS_C2;
    localparam int LAMP_PIN  = 53;
    localparam int LAMP_BIT  = 24;
    localparam int WIN_W     = 12;

    localparam logic [NUM_CTRL-1:0][WORD_W-1:0] CTRL_BASE = {
        32'hFF70_A000, 32'hFF70_9000, 32'hFF70_8000};
    localparam logic [NUM_CTRL-1:0][WORD_W-1:0] CTRL_IO_MASK = {
        32'h0000_1FFF, 32'h1FFF_FFFF, 32'h1FFF_FFFF};

    localparam logic [WIN_W-1:0]  OFS_LEVEL  = 12'h000;
    localparam logic [WIN_W-1:0]  OFS_DIR    = 12'h004;
    localparam logic [WIN_W-1:0]  OFS_SAMPLE = 12'h008;

    localparam logic [WORD_W-1:0] LEVEL_RESET = 32'h0000_0000;
    localparam logic [WORD_W-1:0] DIR_RESET   = 32'h0000_0000;
    localparam logic [WORD_W-1:0] WORD_ZERO   = 32'h0000_0000;
endpackage

// ### hdl/pgb_pin_sync.sv
// Purpose: Two-stage synchroniser for every pin that the bank samples.
// Assumes: Pins are asynchronous to clock_in.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/1ps
module pgb_pin_sync
    import pgb_pkg::*;
(
    input  wire logic                clock_in,
    input  wire logic                reset_n_in,
    input  wire logic [PINS_ALL-1:0] pins_in,
    output logic      [PINS_ALL-1:0] pins_out
);
    typedef struct packed {
        logic [PINS_ALL-1:0] meta;
        logic [PINS_ALL-1:0] stable;
    } pgb_sync_t;

    pgb_sync_t st_q;
    pgb_sync_t st_d;

    always_comb begin
        st_d        = st_q;
        st_d.meta   = pins_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pins_out = st_q.stable;
endmodule

// ### hdl/pgb_gpio_bank.sv
// Purpose: Bank of three memory-mapped general-purpose I/O controllers.
// Assumes: Word-wide memory-mapped reads and writes; pins asynchronous to clock_in.
// Notes:   A pin is driven only while its direction bit is 1; otherwise its enable is low.
`timescale 1ns/1ps
module pgb_gpio_bank
    import pgb_pkg::*;
(
    input  wire logic                clock_in,
    input  wire logic                reset_n_in,
    input  wire logic [WORD_W-1:0]   bus_addr_in,
    input  wire logic                bus_write_in,
    input  wire logic                bus_read_in,
    input  wire logic [WORD_W-1:0]   bus_wdata_in,
    output logic      [WORD_W-1:0]   bus_rdata_out,
    output logic                     bus_rvalid_out,
    input  wire logic [PINS_IO-1:0]  pin_level_in,
    output logic      [PINS_IO-1:0]  pin_level_out,
    output logic      [PINS_IO-1:0]  pin_drive_en_out,
    input  wire logic [PINS_INP-1:0] input_only_pins_in,
    output logic                     user_lamp_pin_out
);
    typedef struct packed {
        logic [NUM_CTRL-1:0][WORD_W-1:0] level;
        logic [NUM_CTRL-1:0][WORD_W-1:0] dir;
        logic [WORD_W-1:0]               rdata;
        logic                            rvalid;
    } pgb_state_t;

    pgb_state_t st_q;
    pgb_state_t st_d;

    logic [PINS_ALL-1:0]             sampled;
    logic [NUM_CTRL-1:0][WORD_W-1:0] sample_word;
    logic [NUM_CTRL-1:0]             hit;
    logic [WIN_W-1:0]                offset;

    pgb_pin_sync u_sync (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .pins_in    ({input_only_pins_in, pin_level_in}),
        .pins_out   (sampled)
    );

    // Each controller sees its own pins from bit 0 upward; unused upper bits read zero.
    always_comb begin
        sample_word    = '0;
        sample_word[0][PINS_C0-1:0] = sampled[C1_LOW-1:0];
        sample_word[1][PINS_C1-1:0] = sampled[C2_LOW-1:C1_LOW];
        sample_word[2][PINS_C2-1:0] = sampled[PINS_IO-1:C2_LOW];
        sample_word[2][INP_LOW+PINS_INP-1:INP_LOW] = sampled[PINS_ALL-1:PINS_IO];
    end

    assign offset = bus_addr_in[WIN_W-1:0];

    genvar c;
    generate
        for (c = 0; c < NUM_CTRL; c++) begin : g_dec
            // Misaligned addresses hit nothing, so they write nothing and a read answers with a zero word.
            assign hit[c] = (bus_addr_in[WORD_W-1:WIN_W] == CTRL_BASE[c][WORD_W-1:WIN_W]) &&
                            (bus_addr_in[1:0] == 2'b00);
        end
    endgenerate

    always_comb begin
        st_d        = st_q;
        st_d.rvalid = bus_read_in;
        for (int i = 0; i < NUM_CTRL; i++) begin
            if (hit[i] && bus_write_in) begin
                unique case (offset)
                    OFS_LEVEL: st_d.level[i] = bus_wdata_in & CTRL_IO_MASK[i];
                    OFS_DIR:   st_d.dir[i]   = bus_wdata_in & CTRL_IO_MASK[i];
                    default:   ;
                endcase
            end
        end
        if (bus_read_in) begin
            st_d.rdata = WORD_ZERO;
            for (int i = 0; i < NUM_CTRL; i++) begin
                if (hit[i]) begin
                    unique case (offset)
                        OFS_LEVEL:  st_d.rdata = st_q.level[i];
                        OFS_DIR:    st_d.rdata = st_q.dir[i];
                        OFS_SAMPLE: st_d.rdata = sample_word[i];
                        default:    st_d.rdata = WORD_ZERO;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_CTRL; i++) begin
                st_q.level[i] <= LEVEL_RESET;
                st_q.dir[i]   <= DIR_RESET;
            end
            st_q.rdata  <= WORD_ZERO;
            st_q.rvalid <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus_rdata_out    = st_q.rdata;
    assign bus_rvalid_out   = st_q.rvalid;
    // Level is presented even while the enable is low; the pad ignores it then.
    assign pin_level_out    = {st_q.level[2][PINS_C2-1:0], st_q.level[1][PINS_C1-1:0],
                               st_q.level[0][PINS_C0-1:0]};
    assign pin_drive_en_out = {st_q.dir[2][PINS_C2-1:0], st_q.dir[1][PINS_C1-1:0],
                               st_q.dir[0][PINS_C0-1:0]};
    assign user_lamp_pin_out = st_q.level[1][LAMP_BIT];

    localparam logic [WORD_W-1:0] A_C0_LEVEL  = CTRL_BASE[0] | {20'h0_0000, OFS_LEVEL};
    localparam logic [WORD_W-1:0] A_C1_LEVEL  = CTRL_BASE[1] | {20'h0_0000, OFS_LEVEL};
    localparam logic [WORD_W-1:0] A_C1_DIR    = CTRL_BASE[1] | {20'h0_0000, OFS_DIR};
    localparam logic [WORD_W-1:0] A_C1_SAMPLE = CTRL_BASE[1] | {20'h0_0000, OFS_SAMPLE};
    localparam logic [WORD_W-1:0] A_C2_DIR    = CTRL_BASE[2] | {20'h0_0000, OFS_DIR};
    localparam logic [WORD_W-1:0] A_C2_SAMPLE = CTRL_BASE[2] | {20'h0_0000, OFS_SAMPLE};
    localparam logic [WORD_W-1:0] A_C0_DIR    = CTRL_BASE[0] | {20'h0_0000, OFS_DIR};
    localparam logic [WORD_W-1:0] A_C0_SAMPLE = CTRL_BASE[0] | {20'h0_0000, OFS_SAMPLE};
    localparam logic [WORD_W-1:0] A_C2_LEVEL  = CTRL_BASE[2] | {20'h0_0000, OFS_LEVEL};

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_dir_out;
        bus_write_in && bus_addr_in == A_C1_DIR && bus_wdata_in[LAMP_BIT];
    endsequence
    sequence s_level_high;
        bus_write_in && bus_addr_in == A_C1_LEVEL && bus_wdata_in[LAMP_BIT];
    endsequence

    chk_reset_inputs: assert property (
        $past(!reset_n_in) |-> pin_drive_en_out == '0 && pin_level_out == '0)
        else $error("Pins not released after reset.");
    chk_dir_write: assert property (
        bus_write_in && bus_addr_in == A_C1_DIR |=>
        pin_drive_en_out[C2_LOW-1:C1_LOW] == $past(bus_wdata_in[PINS_C1-1:0]))
        else $error("Direction write did not reach second controller pins.");
    chk_level_write: assert property (
        bus_write_in && bus_addr_in == A_C0_LEVEL |=>
        pin_level_out[PINS_C0-1:0] == $past(bus_wdata_in[PINS_C0-1:0]))
        else $error("Level write did not reach first controller pins.");
    // A few cycles may separate the two writes, so the enable is re-checked at the level write.
    chk_lamp_drive: assert property (
        s_dir_out ##[1:5] s_level_high ##0 pin_drive_en_out[LAMP_PIN] |=>
        pin_drive_en_out[LAMP_PIN] && pin_level_out[LAMP_PIN] && user_lamp_pin_out)
        else $error("Lamp pin not driven high after direction then level.");
    chk_read_latency: assert property (
        bus_read_in |=> bus_rvalid_out ##1 (bus_rvalid_out == $past(bus_read_in)))
        else $error("Read answer not one cycle after request.");
    chk_sample_read: assert property (
        bus_read_in && bus_addr_in == A_C1_SAMPLE |=>
        bus_rdata_out == {3'b000, $past(sampled[C2_LOW-1:C1_LOW])})
        else $error("Second controller sample read wrong.");
    chk_input_only_read: assert property (
        bus_read_in && bus_addr_in == A_C2_SAMPLE |=>
        bus_rdata_out[INP_LOW+PINS_INP-1:INP_LOW] == $past(sampled[PINS_ALL-1:PINS_IO]))
        else $error("Input-only pins not returned by third controller.");
    chk_third_base: assert property (
        bus_write_in && bus_addr_in == A_C2_DIR |=>
        pin_drive_en_out[PINS_IO-1:C2_LOW] == $past(bus_wdata_in[PINS_C2-1:0]))
        else $error("Third controller window not decoded.");
    chk_unmapped_zero: assert property (
        bus_read_in && hit == '0 |=> bus_rdata_out == WORD_ZERO)
        else $error("Unmapped read returned nonzero.");
    // Software polls the sample word freely, so a read must never disturb the pins.
    chk_read_quiet: assert property (
        bus_read_in && !bus_write_in |=>
        $stable(pin_level_out) && $stable(pin_drive_en_out))
        else $error("Read disturbed pin outputs.");
    chk_rvalid_idle: assert property (
        !bus_read_in |=>
        !bus_rvalid_out)
        else $error("Read answer without a request.");
    chk_lamp_level: assert property (
        bus_write_in && bus_addr_in == A_C1_LEVEL |=>
        user_lamp_pin_out == $past(bus_wdata_in[LAMP_BIT]))
        else $error("Lamp output does not follow its level bit.");
    chk_first_dir: assert property (
        bus_write_in && bus_addr_in == A_C0_DIR |=>
        pin_drive_en_out[PINS_C0-1:0] == $past(bus_wdata_in[PINS_C0-1:0]))
        else $error("Direction write did not reach first controller pins.");
    chk_third_level: assert property (
        bus_write_in && bus_addr_in == A_C2_LEVEL |=>
        pin_level_out[PINS_IO-1:C2_LOW] == $past(bus_wdata_in[PINS_C2-1:0]))
        else $error("Level write did not reach third controller pins.");
    chk_sample_write: assert property (
        bus_write_in && bus_addr_in == A_C1_SAMPLE |=>
        $stable(pin_level_out) && $stable(pin_drive_en_out))
        else $error("Write to sample word changed the pins.");
    chk_level_read: assert property (
        bus_read_in && bus_addr_in == A_C0_LEVEL |=>
        bus_rdata_out == WORD_W'($past(pin_level_out[PINS_C0-1:0])))
        else $error("First controller level read wrong.");
    chk_first_sample: assert property (
        bus_read_in && bus_addr_in == A_C0_SAMPLE |=>
        bus_rdata_out == WORD_W'($past(sampled[C1_LOW-1:0])))
        else $error("First controller sample read wrong.");
    chk_dir_upper: assert property (
        bus_read_in && bus_addr_in == A_C1_DIR |=>
        bus_rdata_out[WORD_W-1:PINS_C1] == '0)
        else $error("Second controller direction upper bits not zero.");
    chk_third_upper: assert property (
        bus_read_in && bus_addr_in == A_C2_DIR |=>
        bus_rdata_out[WORD_W-1:PINS_C2] == '0)
        else $error("Third controller direction upper bits not zero.");
endmodule

// ### tb/pgb_board_model.sv
// Purpose: Board model of the lamp and push-buttons on the bank's pins.
// Assumes: A released pin shows the board level given on board_level_in.
// Notes:   Input-only pins always show the board level.
`timescale 1ns/1ps
module pgb_board_model
    import pgb_pkg::*;
(
    input  wire logic [PINS_ALL-1:0] board_level_in,
    input  wire logic [PINS_IO-1:0]  drive_level_in,
    input  wire logic [PINS_IO-1:0]  drive_en_in,
    output logic      [PINS_IO-1:0]  pin_level_out,
    output logic      [PINS_INP-1:0] input_only_out
);
    // A driven pin follows the bank; a released pin falls back to its board pull level.
    assign pin_level_out  = (drive_en_in & drive_level_in) |
                            (~drive_en_in & board_level_in[PINS_IO-1:0]);
    assign input_only_out = board_level_in[PINS_ALL-1:PINS_IO];
endmodule

// ### tb/tb_pgb_gpio_bank.sv
// Purpose: Self-checking bench for the three-controller I/O bank.
// Assumes: Inputs change on the falling edge; reads answer one cycle after the strobe.
// Notes:   Pin samples pass two flops, so reads wait three cycles after a board change.
`timescale 1ns/1ps
module tb_pgb_gpio_bank
    import pgb_pkg::*;
;
    logic              clock_in = 1'b0;
    logic              reset_n_in = 1'b0;
    logic [WORD_W-1:0] addr = '0, wd = '0, rdata, rv;
    logic              we = 1'b0, re = 1'b0, rvalid, lamp;
    logic [PINS_IO-1:0] pin_in, pin_out, en;
    logic [PINS_INP-1:0] in_only;
    logic [WORD_W-1:0]   exp_word;
    logic [95:0]       ext = '0;
    int                errors = 0, checks_done = 0, lo;

    always #5 clock_in = ~clock_in;

    pgb_gpio_bank pgb_gpio_bank_inst (.clock_in(clock_in), .reset_n_in(reset_n_in), .bus_addr_in(addr),
        .bus_write_in(we), .bus_read_in(re), .bus_wdata_in(wd), .bus_rdata_out(rdata), .bus_rvalid_out(rvalid),
        .pin_level_in(pin_in), .pin_level_out(pin_out), .pin_drive_en_out(en), .input_only_pins_in(in_only),
        .user_lamp_pin_out(lamp));
    pgb_board_model pgb_board_model_inst (.board_level_in(ext[PINS_ALL-1:0]), .drive_level_in(pin_out),
        .drive_en_in(en), .pin_level_out(pin_in), .input_only_out(in_only));

    task automatic test_done();
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] d);
        @(negedge clock_in);
        addr = a;
        wd   = d;
        we   = 1'b1;
        @(negedge clock_in);
        we = 1'b0;
    endtask

    // The strobe is held for exactly one edge, so each call is one read.
    task automatic rd(input logic [WORD_W-1:0] a);
        @(negedge clock_in);
        addr = a;
        re   = 1'b1;
        @(negedge clock_in);
        re = 1'b0;
        for (int i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clock_in);
        if (rvalid !== 1'b1) begin
            errors++;
            test_done();
        end
        rv = rdata;
    endtask

    initial begin
        repeat (10) @(negedge clock_in);
        reset_n_in = 1'b1;
        for (int c = 0; c < NUM_CTRL; c++) begin
            lo = (c == 0) ? 0 : (c == 1) ? C1_LOW : C2_LOW;
            rd(CTRL_BASE[c] + OFS_DIR);
            check("dir reset", rv, DIR_RESET);
            rd(CTRL_BASE[c] + OFS_LEVEL);
            check("level reset", rv, LEVEL_RESET);
            wr(CTRL_BASE[c] + OFS_DIR, 32'hFFFF_FFFF);
            wr(CTRL_BASE[c] + OFS_LEVEL, 32'hA5A5_5A5A ^ c);
            rd(CTRL_BASE[c] + OFS_DIR);
            check("dir read", rv, CTRL_IO_MASK[c]);
            check("drive enable", WORD_W'(en >> lo), CTRL_IO_MASK[c]);
            check("pin level", WORD_W'(pin_out >> lo), (32'hA5A5_5A5A ^ c) & CTRL_IO_MASK[c]);
            repeat (3) @(negedge clock_in);
            rd(CTRL_BASE[c] + OFS_SAMPLE);
            exp_word = (32'hA5A5_5A5A ^ c) & CTRL_IO_MASK[c];
            check("driven sample", rv & CTRL_IO_MASK[c], exp_word);
            wr(CTRL_BASE[c] + OFS_DIR, WORD_ZERO);
            check("released", WORD_W'(en >> lo), WORD_ZERO);
            ext = {3{32'h3C96_E15A ^ c}};
            repeat (3) @(negedge clock_in);
            rd(CTRL_BASE[c] + OFS_SAMPLE);
            exp_word = (WORD_W'(ext >> lo) & CTRL_IO_MASK[c]) |
                       ((c == 2) ? (WORD_W'(ext >> PINS_IO) & 32'h0000_3FFF) << INP_LOW : WORD_ZERO);
            check("sample", rv, exp_word);
            wr(CTRL_BASE[c] + OFS_SAMPLE, 32'hFFFF_FFFF);
            rd(CTRL_BASE[c] + OFS_LEVEL);
            check("sample write ignored", rv, (32'hA5A5_5A5A ^ c) & CTRL_IO_MASK[c]);
        end
        // A misaligned word address must not reach any register.
        wr(CTRL_BASE[0] + OFS_DIR + 32'h0000_0002, 32'hFFFF_FFFF);
        check("misaligned write", WORD_W'(en), WORD_ZERO);
        // Lamp bit set while released, then the direction bit is set by read-modify-write.
        ext = '0;
        wr(CTRL_BASE[1] + OFS_LEVEL, 32'h0100_0000);
        repeat (3) @(negedge clock_in);
        check("lamp released", {31'h0, pin_in[LAMP_PIN]}, WORD_ZERO);
        rd(CTRL_BASE[1] + OFS_DIR);
        wr(CTRL_BASE[1] + OFS_DIR, rv | 32'h0100_0000);
        check("lamp enable", {31'h0, en[LAMP_PIN]}, 32'h0000_0001);
        check("lamp pin", {31'h0, lamp & pin_in[C1_LOW + LAMP_BIT]}, 32'h0000_0001);
        rd(CTRL_BASE[2] + 12'h00C);
        check("unused offset", rv, WORD_ZERO);
        rd(32'hFF70_B000);
        check("unmapped", rv, WORD_ZERO);
        test_done();
    end
endmodule
